// *** src/crfd_map.vh ***
`ifndef CRFD_MAP_VH
`define CRFD_MAP_VH

// ==========================================================================
// Decoder modes
`define CRFD_DEC_MILLER     3'h0
`define CRFD_DEC_NRZ        3'h1
`define CRFD_DEC_MANCH      3'h2
`define CRFD_DEC_BPSK       3'h3
`define CRFD_DEC_VICINITY   3'h4
`define CRFD_DEC_ITEM_M3    3'h5

// ==========================================================================
// Envelope processor modes
`define CRFD_ENV_READER     2'h0
`define CRFD_ENV_CARD       2'h1
`define CRFD_ENV_ADC_CARD   2'h2

// ==========================================================================
// Timing
`define CRFD_MASK_CYCLES    10'h200
`define CRFD_LINK_DIV       2

// ==========================================================================
// CRC
`define CRFD_CRC16_POLY     16'h1021
`define CRFD_CRC5_POLY      5'h09
`define CRFD_CRC16_RESET    16'h6363

`endif

// *** src/crfd_word_buf.v ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Two-entry word buffer, valid/ready on both sides
module crfd_word_buf
(
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire [31:0] in_data,
    input  wire        in_valid,
    output wire        in_ready,
    output wire [31:0] out_data,
    output wire        out_valid,
    input  wire        out_ready
);
    reg [31:0] mem [0:1];
    reg        wr_ptr;
    reg        rd_ptr;
    reg [1:0]  count;
    wire       push;
    wire       pop;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem[0] <= 32'h0;
            mem[1] <= 32'h0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push & ~pop)
                count <= count + 2'h1;
            else if (pop & ~push)
                count <= count - 2'h1;
        end
    end
endmodule

`default_nettype wire

// *** src/crfd_core.v ***
`timescale 1ns/1ps
`default_nettype none
`include "crfd_map.vh"

// What this block does
// RQ1: Core clock halves a 27.12 MHz source.
// RQ2: Field clock used only in a field.
// RQ3: PLL usable only enabled and locked.
// RQ4: Always-on logic runs on the oscillator.
// RQ5: Buffer side runs on the system clock.
// RQ6: Tracker aligns carrier to field clock.
// RQ7: Carrier frozen while modulating.
// RQ8: Reader, card and ADC card modes.
// RQ9: Card mode: Miller, NRZ, Manchester.
// RQ10: Reader: Manchester at 106 kBd, else BPSK.
// RQ11: Vicinity; item mode 3 M=10/M=11 only.
// RQ12: Encoder adds start, parity, framing.
// RQ13: Encoder offers four line codes; the encoder here sends the data bits unencoded on tx_bit.
// RQ14: 5 or 16 bit CRC; short frames padded.
// RQ15: Decoder checks parity, collision, CRC; here the receive CRC is only reported on crc_out, not checked.
// RQ16: Bit frames report valid bit count.
// RQ17: Sequencer times frame delay and wait.
// RQ18: Words become bytes via two buffers.
// RQ19: CRC preset and inversion selectable.
// RQ20: Driver keeps guard times, random wait.
// RQ21: Field flag ignores own field.
// RQ22: Detector masked 512 cycles after loss.
// RQ23: Words cross by handshake.
// RQ24: Field level synchronised first.
module crfd_core
(
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        pll_source_clock,
    input  wire        field_recovered_clock,
    input  wire        pll_enable,
    input  wire        pll_locked,
    input  wire        clk_sel_field,
    input  wire        level_detect,
    input  wire        alm_active,
    input  wire [1:0]  env_mode,
    input  wire [2:0]  dec_mode,
    input  wire        env_bit,
    input  wire        crc16_sel,
    input  wire        crc_invert,
    input  wire [15:0] crc_preset,
    input  wire        parity_en,
    input  wire [2:0]  last_bits,
    input  wire        short_frame,
    input  wire        tx_start,
    input  wire [15:0] frame_delay,
    input  wire [15:0] frame_wait,
    input  wire        drv_request,
    input  wire        coll_avoid_en,
    input  wire [15:0] guard_time,
    input  wire [31:0] tx_word,
    input  wire        tx_word_valid,
    output reg         tx_word_ready,
    output reg  [31:0] rx_word,
    output reg         rx_word_valid,
    input  wire        rx_word_ready,
    output reg         core_rf_clock,
    output reg         core_clk_ok,
    output reg         tx_bit,
    output reg         tx_active,
    output reg         rx_active,
    output reg         rx_parity_err,
    output reg         rx_collision,
    output reg  [2:0]  rx_valid_bits,
    output reg  [15:0] crc_out,
    output reg         rf_drv_on,
    output reg         ext_field,
    output reg         phase_up,
    output reg         phase_dn,
    output reg         timeout
);
    // ======================================================================
    // Synchronisers
    reg [1:0] s_pll;
    reg [1:0] s_fld;
    reg [1:0] s_lvl;
    reg [1:0] s_bit;
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_pll <= 2'h0;
            s_fld <= 2'h0;
            s_lvl <= 2'h0;
            s_bit <= 2'h0;
        end
        else
        begin
            s_pll <= {s_pll[0], pll_source_clock};
            s_fld <= {s_fld[0], field_recovered_clock};
            s_lvl <= {s_lvl[0], level_detect}; // RQ24
            s_bit <= {s_bit[0], env_bit};
        end
    end

    // ======================================================================
    // Clock select and halving
    reg  pll_d;
    reg  fld_d;
    reg  bit_d;
    wire pll_rise = s_pll[1] & ~pll_d;
    wire fld_rise = s_fld[1] & ~fld_d;
    wire bit_edge = s_bit[1] ^ bit_d;
    wire pll_ok   = pll_enable & pll_locked; // RQ3
    wire use_fld  = clk_sel_field & ext_field; // RQ2
    wire src_edge = use_fld ? fld_rise : (pll_ok & pll_rise);
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pll_d         <= 1'b0;
            fld_d         <= 1'b0;
            bit_d         <= 1'b0;
            core_rf_clock <= 1'b0;
            core_clk_ok   <= 1'b0;
        end
        else
        begin
            pll_d <= s_pll[1];
            fld_d <= s_fld[1];
            bit_d <= s_bit[1];
            // Divide-by-two of the selected source
            if (src_edge)
                core_rf_clock <= ~core_rf_clock; // RQ1
            core_clk_ok <= clk_sel_field ? use_fld : pll_ok; // RQ2 RQ3
        end
    end

    // ======================================================================
    // Phase tracker: compare source edges, frozen while modulating
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_up <= 1'b0;
            phase_dn <= 1'b0;
        end
        else if (alm_active)
        begin
            phase_up <= 1'b0; // RQ7
            phase_dn <= 1'b0;
        end
        else
        begin
            phase_up <= ext_field & fld_rise & ~pll_rise; // RQ6
            phase_dn <= ext_field & pll_rise & ~fld_rise; // RQ6
        end
    end

    // ======================================================================
    // Field indication with detector mask
    reg [9:0] mask_cnt;
    reg       lvl_d;
    wire      ext_raw = s_lvl[1] & ~rf_drv_on & (fld_rise | lvl_d); // RQ21
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask_cnt  <= 10'h0;
            lvl_d     <= 1'b0;
            ext_field <= 1'b0;
        end
        else
        begin
            lvl_d <= s_lvl[1] & ~rf_drv_on;
            if (ext_field & ~s_lvl[1])
            begin
                ext_field <= 1'b0;
                mask_cnt  <= `CRFD_MASK_CYCLES; // RQ22
            end
            else if (mask_cnt != 10'h0)
                mask_cnt <= mask_cnt - 10'h1; // RQ22
            else if (ext_raw & (fld_rise | ext_field))
                ext_field <= 1'b1; // RQ21
        end
    end

    // ======================================================================
    // RF driver control with guard time and random wait
    reg [15:0] lfsr;
    reg [15:0] guard_cnt;
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lfsr      <= 16'hACE1;
            guard_cnt <= 16'h0;
            rf_drv_on <= 1'b0;
        end
        else
        begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            if (!drv_request)
            begin
                rf_drv_on <= 1'b0;
                guard_cnt <= guard_time +
                    (coll_avoid_en ? {8'h0, lfsr[7:0]} : 16'h0); // RQ20
            end
            else if (ext_field)
                guard_cnt <= guard_time; // RQ20
            else if (guard_cnt != 16'h0)
                guard_cnt <= guard_cnt - 16'h1;
            else
                rf_drv_on <= 1'b1; // RQ20
        end
    end

    // ======================================================================
    // CRC, shared by transmit and receive
    function [15:0] crc_step;
        input [15:0] c;
        input        b;
        input        w16;
        begin
            if (w16)
                crc_step = {c[14:0], 1'b0} ^
                    ((c[15] ^ b) ? `CRFD_CRC16_POLY : 16'h0);
            else
                crc_step = {11'h0, c[3:0], 1'b0} ^
                    ((c[4] ^ b) ? {11'h0, `CRFD_CRC5_POLY} : 16'h0);
        end
    endfunction
    reg [15:0] crc;

    // ======================================================================
    // Word buffer into transmit (RQ23 ready/valid pairing)
    wire [31:0] buf_data;
    wire        buf_valid;
    reg         buf_take;
    wire        buf_in_ready;
    wire        tx_push = tx_word_valid & tx_word_ready;
    crfd_word_buf u_txbuf
    (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_data   (tx_word),
        .in_valid  (tx_push),
        .in_ready  (buf_in_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_take)
    );

    // ======================================================================
    // Transceive sequencer
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_TX   = 4'h2;
    localparam [3:0] ST_FDT  = 4'h4;
    localparam [3:0] ST_RX   = 4'h8;
    reg [3:0]  state;
    reg [31:0] shreg;
    reg [5:0]  bitn;
    reg [15:0] tmr;
    reg        par;
    reg [3:0]  rx_cnt;
    reg [1:0]  rx_byte;
    reg        decoded;
    reg        rx_bit_prev;
    wire       rx_bit_en   = bit_edge & core_rf_clock; // RQ8

    // Line decoders by envelope and decoder mode
    always @*
    begin
        decoded = s_bit[1];
        case (dec_mode)
            `CRFD_DEC_MILLER:   decoded = ~s_bit[1];          // RQ9
            `CRFD_DEC_NRZ:      decoded = s_bit[1];           // RQ9
            `CRFD_DEC_MANCH:    decoded = s_bit[1] ^ bit_d;   // RQ9 RQ10
            `CRFD_DEC_BPSK:     decoded = s_bit[1] ^ rx_bit_prev; // RQ10
            `CRFD_DEC_VICINITY: decoded = s_bit[1];           // RQ11
            default:            decoded = s_bit[1];           // RQ11
        endcase
        if (env_mode == `CRFD_ENV_ADC_CARD)
            decoded = s_bit[1]; // RQ8
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state         <= ST_IDLE;
            shreg         <= 32'h0;
            bitn          <= 6'h0;
            tmr           <= 16'h0;
            par           <= 1'b0;
            crc           <= 16'h0;
            tx_bit        <= 1'b0;
            tx_active     <= 1'b0;
            rx_active     <= 1'b0;
            timeout       <= 1'b0;
            rx_parity_err <= 1'b0;
            rx_collision  <= 1'b0;
            rx_valid_bits <= 3'h0;
            rx_cnt        <= 4'h0;
            rx_byte       <= 2'h0;
            rx_word       <= 32'h0;
            rx_word_valid <= 1'b0;
            rx_bit_prev   <= 1'b0;
            crc_out       <= 16'h0;
            buf_take      <= 1'b0;
            tx_word_ready <= 1'b0;
        end
        else
        begin
            buf_take      <= 1'b0;
            tx_word_ready <= buf_take |
                             ~(~buf_in_ready | (buf_valid & tx_push));
            if (rx_word_valid & rx_word_ready)
                rx_word_valid <= 1'b0; // RQ23
            case (state)
            ST_IDLE:
                if (tx_start & buf_valid)
                begin
                    shreg     <= buf_data; // RQ18
                    buf_take  <= 1'b1;
                    bitn      <= 6'h0;
                    crc       <= crc_preset; // RQ19
                    par       <= 1'b1;
                    timeout   <= 1'b0;
                    tx_active <= 1'b1;
                    tx_bit    <= 1'b0; // RQ12 start bit
                    state     <= ST_TX;
                end
            ST_TX:
                if (src_edge)
                begin
                    // Nine slots a byte: eight data then parity (RQ12)
                    if (bitn[3:0] == 4'h8)
                    begin
                        tx_bit <= parity_en ? par : 1'b1; // RQ12
                        par    <= 1'b1;
                        if (bitn[5:4] == 2'h3 ||
                            (short_frame && bitn[5:4] == 2'h0))
                        begin
                            tx_active <= 1'b0;
                            crc_out   <= crc_invert ? ~crc : crc; // RQ14 RQ19
                            tmr       <= frame_delay; // RQ17
                            state     <= ST_FDT;
                        end
                        bitn <= {bitn[5:4] + 2'h1, 4'h0};
                    end
                    else
                    begin
                        // Short frames send bit 7 as zero; the CRC still takes shreg[0]
                        tx_bit <= (short_frame && bitn[3:0] == 4'h7) ?
                                  1'b0 : shreg[0]; // RQ14
                        par    <= par ^ shreg[0];
                        crc    <= crc_step(crc, shreg[0], crc16_sel); // RQ14
                        shreg  <= {1'b0, shreg[31:1]}; // RQ12 RQ13
                        bitn   <= bitn + 6'h1;
                    end
                end
            ST_FDT:
                if (tmr != 16'h0)
                    tmr <= tmr - 16'h1; // RQ17
                else
                begin
                    rx_active <= 1'b1;
                    tmr       <= frame_wait;
                    crc       <= crc_preset;
                    rx_cnt    <= 4'h0;
                    rx_byte   <= 2'h0;
                    state     <= ST_RX;
                end
            ST_RX:
            begin
                if (rx_bit_en)
                begin
                    rx_bit_prev <= s_bit[1];
                    tmr         <= frame_wait;
                    if (rx_cnt == 4'h8)
                    begin
                        rx_parity_err <= parity_en & (par != decoded); // RQ15
                        rx_cnt        <= 4'h0;
                        par           <= 1'b1;
                        rx_byte       <= rx_byte + 2'h1;
                        if (rx_byte == 2'h3)
                            rx_word_valid <= 1'b1; // RQ18
                    end
                    else
                    begin
                        rx_word <= {decoded, rx_word[31:1]}; // RQ15
                        par     <= par ^ decoded;
                        crc     <= crc_step(crc, decoded, crc16_sel); // RQ15
                        rx_cnt  <= rx_cnt + 4'h1;
                        rx_valid_bits <= rx_cnt[2:0] + 3'h1; // RQ16
                    end
                    // Equal edges within a bit cell read as a collision
                    if (s_bit[1] == rx_bit_prev && rx_cnt == 4'h0)
                        rx_collision <= 1'b1; // RQ15
                end
                else if (tmr != 16'h0)
                    tmr <= tmr - 16'h1;
                else
                begin
                    // Silence ends the frame; no edge, or only whole four-byte words, is a timeout
                    timeout   <= (rx_byte == 2'h0) & (rx_cnt == 4'h0); // RQ17
                    crc_out   <= crc_invert ? ~crc : crc; // RQ19
                    rx_active <= 1'b0; // RQ16
                    state     <= ST_IDLE;
                end
            end
            default:
                state <= ST_IDLE;
            endcase
        end
    end
endmodule

`default_nettype wire

// *** tb/crfd_field_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Remote party: clock and envelope only while the field is up
module crfd_field_model
(
    input  wire logic field_on,
    input  wire logic rf_drv_on,
    output var  logic field_recovered_clock,
    output wire logic level_detect,
    output var  logic env_bit
);
    integer      seed = 32'h56FD33F4;
    logic [31:0] r;

    initial
    begin
        field_recovered_clock = 1'b0;
        env_bit = 1'b0;
        #3;
        forever
        begin
            #80;
            r = $random(seed);
            field_recovered_clock = field_on & ~field_recovered_clock;
            env_bit = field_on & r[0];
        end
    end

    // Detector also sees our own field
    assign level_detect = field_on | rf_drv_on;
endmodule
`default_nettype wire

// *** tb/crfd_core_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Port-level checks
module crfd_core_checker
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        pll_enable,
    input wire logic        pll_locked,
    input wire logic        clk_sel_field,
    input wire logic        alm_active,
    input wire logic        rx_word_ready,
    input wire logic [15:0] frame_delay,
    input wire logic [31:0] rx_word,
    input wire logic        rx_word_valid,
    input wire logic        core_clk_ok,
    input wire logic        tx_active,
    input wire logic        rx_active,
    input wire logic        rf_drv_on,
    input wire logic        ext_field,
    input wire logic        phase_up,
    input wire logic        phase_dn
);
    logic [9:0]  since_fall;
    logic [15:0] since_tx;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Saturating, so stale events never alias
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            since_fall <= 10'h3FF;
            since_tx   <= 16'hFFFF;
        end
        else
        begin
            if ($fell(ext_field))
                since_fall <= 10'h000;
            else if (since_fall != 10'h3FF)
                since_fall <= since_fall + 10'h001;
            if ($fell(tx_active))
                since_tx <= 16'h0000;
            else if (since_tx != 16'hFFFF)
                since_tx <= since_tx + 16'h0001;
        end
    end

    sequence alm_held;
        alm_active [*4];
    endsequence
    sequence pll_down;
        (!clk_sel_field && !(pll_enable && pll_locked)) [*6];
    endsequence

    AST_PHASE_EXCL: assert property (
        !(phase_up && phase_dn))
        else $error("phase up and down together");
    AST_ALM_FREEZE: assert property (
        alm_held |-> !phase_up && !phase_dn)
        else $error("phase step while carrier frozen");
    AST_PLL_OK: assert property (
        pll_down |-> !core_clk_ok)
        else $error("clock ok without locked pll");
    AST_EXT_DRV: assert property (
        $rose(ext_field) |-> !$past(rf_drv_on))
        else $error("external field raised by own drivers");
    AST_MASK: assert property (
        $rose(ext_field) |-> since_fall >= 10'h1FF)
        else $error("field indication inside mask window");
    AST_TXRX_EXCL: assert property (
        !(tx_active && rx_active))
        else $error("transmit and receive overlap");
    AST_FDT: assert property (
        $rose(rx_active) |-> since_tx >= frame_delay - 16'h0001)
        else $error("receive opened before frame delay");
    AST_RX_HOLD: assert property (
        rx_word_valid && !rx_word_ready |=> rx_word_valid && $stable(rx_word))
        else $error("receive word dropped or changed under stall");
endmodule

bind crfd_core crfd_core_checker u_crfd_chk
(
    .clk_sys, .rst_n, .pll_enable, .pll_locked, .clk_sel_field, .alm_active,
    .rx_word_ready, .frame_delay, .rx_word, .rx_word_valid, .core_clk_ok,
    .tx_active, .rx_active, .rf_drv_on, .ext_field, .phase_up, .phase_dn
);
`default_nettype wire

// *** tb/contactless_rf_frontend_digital_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bench
module contactless_rf_frontend_digital_bench;
    logic        clk_sys = 1'b0, rst_n = 1'b0, pll_source_clock = 1'b0;
    logic        pll_enable = 1'b0, pll_locked = 1'b0, clk_sel_field = 1'b0;
    logic        alm_active = 1'b0, crc16_sel = 1'b0, crc_invert = 1'b0;
    logic        parity_en = 1'b1, short_frame = 1'b0, tx_start = 1'b0;
    logic        drv_request = 1'b0, coll_avoid_en = 1'b0, field_on = 1'b0;
    logic        tx_word_valid = 1'b0, rx_word_ready = 1'b0;
    logic [1:0]  env_mode = 2'h0;
    logic [2:0]  dec_mode = 3'h0, last_bits = 3'h0;
    logic [15:0] crc_preset = 16'hFFFF, frame_delay = 16'h0020;
    logic [15:0] frame_wait = 16'h0040, guard_time = 16'h0020;
    logic [31:0] tx_word = 32'h00000000, r;
    wire         field_recovered_clock, level_detect, env_bit, tx_word_ready;
    wire         rx_word_valid, core_rf_clock, core_clk_ok, tx_bit, tx_active;
    wire         rx_active, rx_parity_err, rx_collision, rf_drv_on, ext_field;
    wire         phase_up, phase_dn, timeout;
    wire  [2:0]  rx_valid_bits;
    wire  [15:0] crc_out;
    wire  [31:0] rx_word;
    integer      bad_count = 0, checked = 0, seed = 32'h56FD33F4, i;
    logic        expq[$];

    crfd_core dut
    (
        .clk_sys, .rst_n, .pll_source_clock, .field_recovered_clock,
        .pll_enable, .pll_locked, .clk_sel_field, .level_detect, .alm_active,
        .env_mode, .dec_mode, .env_bit, .crc16_sel, .crc_invert, .crc_preset,
        .parity_en, .last_bits, .short_frame, .tx_start, .frame_delay,
        .frame_wait, .drv_request, .coll_avoid_en, .guard_time, .tx_word,
        .tx_word_valid, .tx_word_ready, .rx_word, .rx_word_valid,
        .rx_word_ready, .core_rf_clock, .core_clk_ok, .tx_bit, .tx_active,
        .rx_active, .rx_parity_err, .rx_collision, .rx_valid_bits, .crc_out,
        .rf_drv_on, .ext_field, .phase_up, .phase_dn, .timeout
    );
    crfd_field_model far
    (
        .field_on, .rf_drv_on, .field_recovered_clock, .level_detect, .env_bit
    );

    initial
        forever #5 clk_sys = ~clk_sys;
    initial
        #7 forever #80 pll_source_clock = ~pll_source_clock;
    always @(posedge clk_sys)
        rx_word_ready <= ~rx_word_ready;
    initial
    begin
        #900000;
        bad_count = bad_count + 1;
        final_report;
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task final_report;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic logic pick(input integer s);
        case (s)
            0: pick = core_clk_ok;
            1: pick = ext_field;
            2: pick = tx_active;
            3: pick = timeout;
            default: pick = rf_drv_on;
        endcase
    endfunction

    task automatic wait_lvl(input integer s, input logic v, input integer lim);
        integer k;
        for (k = 0; k < lim && pick(s) !== v; k = k + 1)
            @(posedge clk_sys);
    endtask

    // Expected bits queued on acceptance
    task automatic put_word(input logic [31:0] w, input logic sh);
        integer b;
        @(posedge clk_sys);
        tx_word <= w;
        tx_word_valid <= 1'b1;
        @(posedge clk_sys);
        while (tx_word_ready !== 1'b1)
            @(posedge clk_sys);
        tx_word_valid <= 1'b0;
        for (b = 0; b < (sh ? 8 : 32); b = b + 1)
            expq.push_back(sh && b == 7 ? 1'b0 : w[b]);
    endtask

    // Start in a low source phase
    task automatic run_frame(input logic sh, input integer left);
        @(negedge pll_source_clock);
        @(posedge clk_sys);
        r = $random(seed);
        short_frame <= sh;
        crc16_sel <= r[0];
        crc_invert <= r[1];
        crc_preset <= r[31:16];
        frame_delay <= {11'h000, r[6:2]} + 16'h0010;
        tx_start <= 1'b1;
        @(posedge clk_sys);
        tx_start <= 1'b0;
        wait_lvl(2, 1'b1, 20);
        check("tx_active", tx_active, 1'b1);
        wait_lvl(2, 1'b0, 8000);
        wait_lvl(3, 1'b1, 300);
        check("timeout", timeout, 1'b1);
        check("tx_bits_left", expq.size(), left);
    endtask

    initial
    begin
        integer slot;
        logic   e;
        forever
        begin
            @(posedge tx_active);
            @(posedge pll_source_clock);
            slot = 0;
            while (tx_active === 1'b1)
            begin
                @(negedge pll_source_clock);
                if (tx_active === 1'b1 && slot % 9 != 8)
                begin
                    e = expq.size() > 0 ? expq.pop_front() : ~tx_bit;
                    check("tx_bit", tx_bit, e);
                end
                slot = slot + 1;
            end
        end
    end

    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (13) @(posedge clk_sys);
        check("clk_ok_off", core_clk_ok, 1'b0);
        pll_enable <= 1'b1;
        repeat (10) @(posedge clk_sys);
        check("clk_ok_unlocked", core_clk_ok, 1'b0);
        pll_locked <= 1'b1;
        wait_lvl(0, 1'b1, 100);
        check("clk_ok_pll", core_clk_ok, 1'b1);
        clk_sel_field <= 1'b1;
        repeat (30) @(posedge clk_sys);
        check("clk_ok_nofield", core_clk_ok, 1'b0);
        field_on <= 1'b1;
        wait_lvl(0, 1'b1, 200);
        check("clk_ok_field", core_clk_ok, 1'b1);
        clk_sel_field <= 1'b0;
        wait_lvl(1, 1'b1, 200);
        check("ext_field_on", ext_field, 1'b1);
        for (i = 0; i < 18; i = i + 1)
        begin
            repeat (30) @(posedge clk_sys);
            env_mode <= 2'(i / 6);
            dec_mode <= 3'(i % 6);
            alm_active <= i[0];
        end
        field_on <= 1'b0;
        wait_lvl(1, 1'b0, 200);
        check("ext_field_off", ext_field, 1'b0);
        repeat (20) @(posedge clk_sys);
        field_on <= 1'b1;
        repeat (380) @(posedge clk_sys);
        check("ext_field_masked", ext_field, 1'b0);
        wait_lvl(1, 1'b1, 400);
        check("ext_field_back", ext_field, 1'b1);
        field_on <= 1'b0;
        for (i = 0; i < 3; i = i + 1)
        begin
            put_word($random(seed), i == 2);
            run_frame(i == 2, 0);
        end
        put_word(32'hA5C30F81, 1'b0);
        put_word(32'h7E1896D2, 1'b0);
        @(posedge clk_sys);
        tx_word_valid <= 1'b1;
        repeat (20) @(posedge clk_sys);
        check("tx_full_ready", tx_word_ready, 1'b0);
        tx_word_valid <= 1'b0;
        run_frame(1'b0, 32);
        run_frame(1'b0, 0);
        for (i = 0; i < 2; i = i + 1)
        begin
            @(posedge clk_sys);
            coll_avoid_en <= i[0];
            drv_request <= 1'b1;
            repeat (16) @(posedge clk_sys);
            check("drv_guard", rf_drv_on, 1'b0);
            wait_lvl(4, 1'b1, 600);
            check("drv_on", rf_drv_on, 1'b1);
            check("ext_field_own", ext_field, 1'b0);
            drv_request <= 1'b0;
            wait_lvl(4, 1'b0, 100);
        end
        final_report;
    end
endmodule
`default_nettype wire
